/* File: logic/position_counter_pkg.sv */
// Package with register map, field positions and types of the position counter.
package position_counter_pkg;

  // Register byte offsets.
  localparam logic [3:0] OFF_CONTROL  = 4'h0;
  localparam logic [3:0] OFF_WRAP     = 4'h4;
  localparam logic [3:0] OFF_COMPARE  = 4'h8;
  localparam logic [3:0] OFF_CAPTURE  = 4'hC;

  // Control register field positions.
  localparam int unsigned CTL_MODE_LO     = 0;
  localparam int unsigned CTL_INDEX_EN    = 2;
  localparam int unsigned CTL_THREE_PHASE = 3;
  localparam int unsigned CTL_RUN         = 4;
  localparam int unsigned CTL_CMP_EN      = 5;
  localparam int unsigned CTL_CLEAR       = 6;
  localparam int unsigned CTL_SOFT_CAP    = 7;
  localparam int unsigned CTL_DIR         = 8;
  localparam int unsigned CTL_REV_ERR     = 9;
  localparam int unsigned CTL_INDEX_SEEN  = 10;
  localparam int unsigned CTL_CMP_HIT     = 11;
  localparam int unsigned CTL_DIV_LO      = 16;

  // Reset values and fixed limits.
  localparam logic [23:0] WRAP_RESET     = 24'h000000;
  localparam logic [23:0] COMPARE_RESET  = 24'h000000;
  localparam logic [23:0] EVENT_LIMIT    = 24'h00FFFF;
  localparam logic [23:0] TIMER_LIMIT    = 24'hFFFFFF;
  localparam logic [7:0]  DIV_RESET      = 8'h00;
  localparam int unsigned FILTER_LEN     = 3;

  // Operating modes, encoded as in the mode field.
  typedef enum logic [1:0] {
    MODE_ENCODER = 2'h0,
    MODE_EVENT   = 2'h1,
    MODE_TIMERCT = 2'h2,
    MODE_TIMER   = 2'h3
  } mode_t;

  // Wishbone request carried as one bundle.
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  // Decoded events of one clock cycle.
  typedef struct packed {
    logic step;
    logic up;
    logic index;
  } step_t;

endpackage : position_counter_pkg

/* File: logic/position_counter.sv */
// Quadrature and Hall position counter with Wishbone register access.
//
// Local design decisions: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
// Operation
// - Encoder A/B gives four steps per cycle.
// - Forward counts up, wraps limit to zero.
// - Reverse counts down, zero reloads wrap limit.
// - Index clears on direction-dependent edge.
// - Index clear beats a coincident step.
// - Counter clear write zeroes counter always.
// - Direction flag high forward, low reverse.
// - Divided pulse output from step clock.
// - Compare match interrupt, gated by index seen in encoder mode with index enabled.
// - Sensor steps: four from UV, six UVW.
// - Event count up wraps 0xFFFF to zero.
// - Event count down wraps zero to 0xFFFF.
// - Timer count runs on clock, step clears.
// - Timer count step copies counter to capture.
// - Soft capture copies counter any time.
// - Run enable low forces direction flag low.
// - Reverse error set on change, read clears.
// - Capture kept regardless of run, reset only.
// - Timer mode is 24-bit up counter.
// - Mode codes 00,01,10,11 select modes.
module position_counter #(
  parameter int unsigned FILT = position_counter_pkg::FILTER_LEN
) (
  // Clock and reset.
  input  wire logic                        clk,
  input  wire logic                        nrst,
  // Wishbone slave.
  input  wire position_counter_pkg::wb_req_t wb_req,
  output logic [31:0]                      wb_dat_o,
  output logic                             wb_ack_o,
  // Sensor pins: A/U, B/V, W, index Z.
  input  wire logic                        phase_a_input,
  input  wire logic                        phase_b_input,
  input  wire logic                        phase_w_input,
  input  wire logic                        index_input,
  // Outputs.
  output logic                             position_irq,
  output logic                             divided_pulse_out
);

  //////////////////////////////////////////////////////////////////////////////
  // Registers.
  position_counter_pkg::mode_t mode_q;
  logic        index_en_q, three_phase_enable_q, run_enable_q, compare_enable_q;
  logic        direction_flag_q, reverse_error_q, index_seen_q, cmp_hit_q;
  logic [7:0]  div_q;
  logic [23:0] wrap_q, compare_q, count_q, capture_q;
  logic [7:0]  div_cnt_q;
  logic        wb_ack_q;

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and noise filters.
  logic [3:0] pin_raw;
  logic [3:0] sync1_q, sync2_q, filt_q, filt_prev_q;
  logic [3:0] stable_q [FILT];

  assign pin_raw = {index_input, phase_w_input, phase_b_input, phase_a_input};

  // Two flip-flops bring each pin into the clock domain.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end

  // A level is accepted only after it holds for FILT+1 cycles.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_filt
      logic agree;
      always_comb begin
        agree = 1'b1;
        for (int k = 0; k < FILT; k++) begin
          if (stable_q[k][gi] != sync2_q[gi]) begin
            agree = 1'b0;
          end
        end
      end
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          filt_q[gi] <= 1'b0;
        end else if (agree) begin
          filt_q[gi] <= sync2_q[gi];
        end
      end
    end
  endgenerate

  // Shift history of synchronised levels for the filter.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int k = 0; k < FILT; k++) begin
        stable_q[k] <= 4'h0;
      end
      filt_prev_q <= 4'h0;
    end else begin
      stable_q[0] <= sync2_q;
      for (int k = 1; k < FILT; k++) begin
        stable_q[k] <= stable_q[k-1];
      end
      filt_prev_q <= filt_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Step decoding.
  // Gray position of A/B: 00,10,11,01 forward.
  function automatic logic [1:0] quad_pos(input logic a, input logic b);
    case ({a, b})
      2'b00:   quad_pos = 2'd0;
      2'b10:   quad_pos = 2'd1;
      2'b11:   quad_pos = 2'd2;
      default: quad_pos = 2'd3;
    endcase
  endfunction : quad_pos

  // Hall sector of U/V/W; 7 marks an illegal pattern.
  function automatic logic [2:0] hall_pos(input logic u, input logic v, input logic w);
    case ({u, v, w})
      3'b100:  hall_pos = 3'd0;
      3'b110:  hall_pos = 3'd1;
      3'b010:  hall_pos = 3'd2;
      3'b011:  hall_pos = 3'd3;
      3'b001:  hall_pos = 3'd4;
      3'b101:  hall_pos = 3'd5;
      default: hall_pos = 3'd7;
    endcase
  endfunction : hall_pos

  position_counter_pkg::step_t ev;
  logic [1:0] qn, qo;
  logic [2:0] hn, ho, hn_inc, ho_inc;
  logic       z_rise, z_fall;

  // One step per qualified transition; index edge chosen by direction.
  always_comb begin
    ev     = '0;
    qn     = quad_pos(filt_q[0], filt_q[1]);
    qo     = quad_pos(filt_prev_q[0], filt_prev_q[1]);
    hn     = hall_pos(filt_q[0], filt_q[1], filt_q[2]);
    ho     = hall_pos(filt_prev_q[0], filt_prev_q[1], filt_prev_q[2]);
    hn_inc = (hn == 3'd5) ? 3'd0 : hn + 3'd1;
    ho_inc = (ho == 3'd5) ? 3'd0 : ho + 3'd1;
    z_rise = filt_q[3] & ~filt_prev_q[3];
    z_fall = ~filt_q[3] & filt_prev_q[3];
    if (mode_q == position_counter_pkg::MODE_ENCODER || !three_phase_enable_q) begin
      if (qn == qo + 2'd1) begin
        ev.step = 1'b1;
        ev.up   = 1'b1;
      end else if (qo == qn + 2'd1) begin
        ev.step = 1'b1;
      end
    end else if (hn != 3'd7 && ho != 3'd7) begin
      if (hn == ho_inc) begin
        ev.step = 1'b1;
        ev.up   = 1'b1;
      end else if (ho == hn_inc) begin
        ev.step = 1'b1;
      end
    end
    ev.index = index_en_q && mode_q == position_counter_pkg::MODE_ENCODER
               && (direction_flag_q ? z_rise : z_fall);
    if (!run_enable_q) begin
      ev = '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode.
  logic        acc, wr, rd;
  logic [31:0] wdat;
  assign acc  = wb_req.cyc & wb_req.stb & ~wb_ack_q;
  assign wr   = acc & wb_req.we;
  assign rd   = acc & ~wb_req.we;
  // Byte lanes that sel leaves out are zeroed.
  always_comb begin
    wdat = 32'h0;
    for (int b = 0; b < 4; b++) begin
      wdat[b*8 +: 8] = wb_req.sel[b] ? wb_req.dat[b*8 +: 8] : 8'h00;
    end
  end
  logic ctl_wr, clr_cmd, cap_cmd;
  assign ctl_wr  = wr && wb_req.adr == position_counter_pkg::OFF_CONTROL && wb_req.sel[0];
  assign clr_cmd = ctl_wr && wdat[position_counter_pkg::CTL_CLEAR];
  assign cap_cmd = ctl_wr && wdat[position_counter_pkg::CTL_SOFT_CAP];

  // Configuration registers.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_q               <= position_counter_pkg::MODE_ENCODER;
      index_en_q           <= 1'b0;
      three_phase_enable_q <= 1'b0;
      run_enable_q         <= 1'b0;
      compare_enable_q     <= 1'b0;
      div_q                <= position_counter_pkg::DIV_RESET;
      wrap_q               <= position_counter_pkg::WRAP_RESET;
      compare_q            <= position_counter_pkg::COMPARE_RESET;
    end else if (wr) begin
      case (wb_req.adr)
        position_counter_pkg::OFF_CONTROL: begin
          if (wb_req.sel[0]) begin
            mode_q               <= position_counter_pkg::mode_t'(wdat[1:0]);
            index_en_q           <= wdat[position_counter_pkg::CTL_INDEX_EN];
            three_phase_enable_q <= wdat[position_counter_pkg::CTL_THREE_PHASE];
            run_enable_q         <= wdat[position_counter_pkg::CTL_RUN];
            compare_enable_q     <= wdat[position_counter_pkg::CTL_CMP_EN];
          end
          if (wb_req.sel[2]) begin
            div_q <= wdat[position_counter_pkg::CTL_DIV_LO +: 8];
          end
        end
        position_counter_pkg::OFF_WRAP:    wrap_q    <= wdat[23:0];
        position_counter_pkg::OFF_COMPARE: compare_q <= wdat[23:0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Position counter.
  logic timer_tick;
  assign timer_tick = run_enable_q && (mode_q == position_counter_pkg::MODE_TIMERCT
                      || mode_q == position_counter_pkg::MODE_TIMER);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_q <= 24'h000000;
    end else if (clr_cmd) begin
      count_q <= 24'h000000;
    end else if (ev.index) begin
      count_q <= 24'h000000;
    end else begin
      case (mode_q)
        position_counter_pkg::MODE_ENCODER: begin
          if (ev.step && ev.up) begin
            count_q <= (count_q >= wrap_q) ? 24'h000000 : count_q + 24'h000001;
          end else if (ev.step) begin
            count_q <= (count_q == 24'h000000) ? wrap_q : count_q - 24'h000001;
          end
        end
        position_counter_pkg::MODE_EVENT: begin
          if (ev.step && ev.up) begin
            count_q <= (count_q >= position_counter_pkg::EVENT_LIMIT) ? 24'h000000
                       : count_q + 24'h000001;
          end else if (ev.step) begin
            count_q <= (count_q == 24'h000000) ? position_counter_pkg::EVENT_LIMIT
                       : count_q - 24'h000001;
          end
        end
        default: begin
          if (mode_q == position_counter_pkg::MODE_TIMERCT && ev.step) begin
            count_q <= 24'h000000;
          end else if (timer_tick) begin
            count_q <= count_q + 24'h000001;
          end
        end
      endcase
    end
  end

  // Capture register: only reset clears it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      capture_q <= 24'h000000;
    end else if (cap_cmd) begin
      capture_q <= count_q;
    end else if (mode_q == position_counter_pkg::MODE_TIMERCT && ev.step) begin
      capture_q <= count_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Direction, reverse error, index seen and compare flags.
  logic ctl_rd, cmp_match;
  assign ctl_rd    = rd && wb_req.adr == position_counter_pkg::OFF_CONTROL;
  assign cmp_match = compare_enable_q && count_q == compare_q
                     && !(mode_q == position_counter_pkg::MODE_ENCODER && index_en_q && !index_seen_q);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      direction_flag_q <= 1'b0;
      reverse_error_q  <= 1'b0;
      index_seen_q     <= 1'b0;
      cmp_hit_q        <= 1'b0;
    end else begin
      if (!run_enable_q) begin
        direction_flag_q <= 1'b0;
      end else if (ev.step) begin
        direction_flag_q <= ev.up;
      end
      // Hardware set beats a same-cycle read clear.
      if (ev.step && run_enable_q && ev.up != direction_flag_q) begin
        reverse_error_q <= 1'b1;
      end else if (ctl_rd) begin
        reverse_error_q <= 1'b0;
      end
      if (ev.index) begin
        index_seen_q <= 1'b1;
      end else if (!index_en_q) begin
        index_seen_q <= 1'b0;
      end
      cmp_hit_q <= cmp_match;
    end
  end
  assign position_irq = cmp_match & ~cmp_hit_q;

  //////////////////////////////////////////////////////////////////////////////
  // Divided pulse: toggles every div+1 steps, except in MODE_TIMER.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt_q         <= 8'h00;
      divided_pulse_out <= 1'b0;
    end else if (ev.step && mode_q != position_counter_pkg::MODE_TIMER) begin
      if (div_cnt_q >= div_q) begin
        div_cnt_q         <= 8'h00;
        divided_pulse_out <= ~divided_pulse_out;
      end else begin
        div_cnt_q <= div_cnt_q + 8'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data and acknowledge, one cycle after the request.
  logic [31:0] rdat;
  always_comb begin
    rdat = 32'h0;
    case (wb_req.adr)
      position_counter_pkg::OFF_CONTROL: begin
        rdat[1:0]                                 = mode_q;
        rdat[position_counter_pkg::CTL_INDEX_EN]    = index_en_q;
        rdat[position_counter_pkg::CTL_THREE_PHASE] = three_phase_enable_q;
        rdat[position_counter_pkg::CTL_RUN]         = run_enable_q;
        rdat[position_counter_pkg::CTL_CMP_EN]      = compare_enable_q;
        rdat[position_counter_pkg::CTL_DIR]         = direction_flag_q;
        rdat[position_counter_pkg::CTL_REV_ERR]     = reverse_error_q;
        rdat[position_counter_pkg::CTL_INDEX_SEEN]  = index_seen_q;
        rdat[position_counter_pkg::CTL_CMP_HIT]     = cmp_hit_q;
        rdat[position_counter_pkg::CTL_DIV_LO +: 8] = div_q;
      end
      position_counter_pkg::OFF_WRAP:    rdat[23:0] = wrap_q;
      position_counter_pkg::OFF_COMPARE: rdat[23:0] = compare_q;
      position_counter_pkg::OFF_CAPTURE: begin
        rdat[23:0] = capture_q;
        if (mode_q == position_counter_pkg::MODE_ENCODER || mode_q == position_counter_pkg::MODE_EVENT) begin
          rdat[23:16] = 8'h00;
        end
      end
      default: rdat = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_q <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_q <= acc;
      wb_dat_o <= rd ? rdat : 32'h0;
    end
  end
  assign wb_ack_o = wb_ack_q;

endmodule : position_counter

/* File: tb/position_counter_checker.sv */
// Checker that watches the ports of the position counter.
`timescale 1ns/1ps
module position_counter_checker #(
  parameter int unsigned FILT = 3
) (
  // Clock and reset.
  input wire logic                          clk,
  input wire logic                          nrst,
  // Register bus.
  input wire position_counter_pkg::wb_req_t wb_req,
  input wire logic [31:0]                   wb_dat_o,
  input wire logic                          wb_ack_o,
  // Sensor pins and outputs.
  input wire logic                          phase_a_input,
  input wire logic                          phase_b_input,
  input wire logic                          phase_w_input,
  input wire logic                          index_input,
  input wire logic                          position_irq,
  input wire logic                          divided_pulse_out
);
  logic       take;
  logic       rdc_q;
  logic       rdp_q;
  logic       cmp_q;
  logic [1:0] mode_q;
  logic [2:0] ph_q;
  logic [4:0] quiet_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  assign take = wb_req.cyc && wb_req.stb && !wb_ack_o;
  // Remembers reads in flight and the fields that software wrote.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdc_q  <= 1'b0;
      rdp_q  <= 1'b0;
      cmp_q  <= 1'b0;
      mode_q <= 2'h0;
    end else begin
      rdc_q <= take && !wb_req.we && wb_req.adr == position_counter_pkg::OFF_CONTROL;
      rdp_q <= take && !wb_req.we && wb_req.adr == position_counter_pkg::OFF_CAPTURE;
      if (take && wb_req.we && wb_req.sel[0] && wb_req.adr == position_counter_pkg::OFF_CONTROL) begin
        mode_q <= wb_req.dat[1:0];
        cmp_q  <= wb_req.dat[5];
      end
    end
  end
  // Counts cycles since a phase input last moved, saturating.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ph_q    <= 3'h0;
      quiet_q <= 5'h00;
    end else begin
      ph_q    <= {phase_a_input, phase_b_input, phase_w_input};
      quiet_q <= (ph_q != {phase_a_input, phase_b_input, phase_w_input}) ? 5'h00 : quiet_q + 5'(quiet_q != 5'h1F);
    end
  end
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_take; take |=> wb_ack_o; endproperty
  a_ack_take: assert property (p_ack_take) else $error("request not answered next cycle");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_irq_pulse; position_irq |=> !position_irq; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt pulse too long");
  property p_irq_en; position_irq |-> cmp_q; endproperty
  a_irq_en: assert property (p_irq_en) else $error("interrupt while compare disabled");
  property p_ctl_wo; wb_ack_o && rdc_q |-> wb_dat_o[7:6] == 2'h0; endproperty
  a_ctl_wo: assert property (p_ctl_wo) else $error("clear or capture bit reads one");
  property p_dir_run; wb_ack_o && rdc_q && !wb_dat_o[4] |-> !wb_dat_o[8]; endproperty
  a_dir_run: assert property (p_dir_run) else $error("direction set while stopped");
  property p_cap_hi; wb_ack_o && rdp_q && !mode_q[1] |-> wb_dat_o[31:16] == 16'h0; endproperty
  a_cap_hi: assert property (p_cap_hi) else $error("capture high bits set");
  property p_div_quiet; quiet_q > FILT + 8 && mode_q != 2'h3 |-> $stable(divided_pulse_out); endproperty
  a_div_quiet: assert property (p_div_quiet) else $error("divided pulse moved without input");
  c_irq: cover property (position_irq);
  c_div: cover property ($rose(divided_pulse_out));
  c_cap: cover property (wb_ack_o && rdp_q);
endmodule : position_counter_checker
bind position_counter position_counter_checker #(.FILT(FILT)) checker_inst (.clk(clk), .nrst(nrst),
  .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .phase_a_input(phase_a_input),
  .phase_b_input(phase_b_input), .phase_w_input(phase_w_input), .index_input(index_input),
  .position_irq(position_irq), .divided_pulse_out(divided_pulse_out));

/* File: tb/sensor_model.sv */
// Behavioural encoder and Hall sensor that drives the position counter's pins.
`timescale 1ns/1ps
module sensor_model #(
  parameter int HOLD = 8
) (
  // Clock that paces the levels.
  input  wire logic clk,
  // Sensor levels.
  output logic      phase_a,
  output logic      phase_b,
  output logic      phase_w,
  output logic      index
);
  localparam logic [2:0] T4 [4] = '{3'h0, 3'h4, 3'h6, 3'h2};
  localparam logic [2:0] T6 [6] = '{3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5};
  int         pos;
  logic [2:0] lv;
  // Idle levels at start.
  initial begin
    phase_a = 1'b0;
    phase_b = 1'b0;
    phase_w = 1'b0;
    index   = 1'b0;
    pos     = 0;
  end
  // Steps one position and holds the levels so the filter can qualify them.
  task automatic move(input bit up, input int three, input int gap);
    pos = up ? (pos + 1) % 12 : (pos + 11) % 12;
    lv  = three ? T6[pos % 6] : T4[pos % 4];
    @(posedge clk);
    phase_a <= lv[2];
    phase_b <= lv[1];
    phase_w <= lv[0];
    repeat (gap) @(posedge clk);
  endtask : move
  // Sets the index level and holds it.
  task automatic zset(input logic v);
    @(posedge clk);
    index <= v;
    repeat (HOLD) @(posedge clk);
  endtask : zset
endmodule : sensor_model

/* File: tb/testbench.sv */
// Self-checking testbench of the position counter.
`timescale 1ns/1ps
module testbench;
  localparam int         HOLD = 8;
  localparam logic [3:0] CTL  = position_counter_pkg::OFF_CONTROL;
  localparam logic [3:0] WRP  = position_counter_pkg::OFF_WRAP;
  localparam logic [3:0] CMPR = position_counter_pkg::OFF_COMPARE;
  localparam logic [3:0] CAP  = position_counter_pkg::OFF_CAPTURE;
  logic                          clk;
  logic                          nrst;
  position_counter_pkg::wb_req_t wb_req;
  logic [31:0]                   wb_dat_o;
  logic                          wb_ack_o;
  logic                          pa;
  logic                          pb;
  logic                          pw;
  logic                          pz;
  logic                          position_irq;
  logic                          divided_pulse_out;
  logic                          dp_p;
  logic [31:0]                   ctl_v;
  logic [31:0]                   c1;
  logic [31:0]                   c2;
  int                            err_total;
  int                            checks;
  int                            irq_n;
  int                            tog_n;
  int                            n;
  int                            cyc_n = 0;
  time                           tk;
  time                           t0;
  time                           t2;
  position_counter #(.FILT(1)) position_counter_inst (.clk(clk), .nrst(nrst), .wb_req(wb_req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .phase_a_input(pa), .phase_b_input(pb), .phase_w_input(pw),
    .index_input(pz), .position_irq(position_irq), .divided_pulse_out(divided_pulse_out));
  sensor_model #(.HOLD(HOLD)) sensor_model_inst (.clk(clk), .phase_a(pa), .phase_b(pb), .phase_w(pw),
    .index(pz));
  // Counts interrupt pulses and divided pulse toggles.
  always @(posedge clk) begin
    if (position_irq === 1'b1) irq_n++;
    if (divided_pulse_out !== dp_p) tog_n++;
    dp_p = divided_pulse_out;
    cyc_n <= cyc_n + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One classic bus cycle; waits for ack under a bound.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    wb_req <= '{1'b1, 1'b1, w, a, 4'hF, d};
    do begin
      @(posedge clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 40);
    if (k >= 40) begin
      err_total++;
      $display("[FAIL] %0t bus acknowledge timed out", $time);
      finish_test();
    end
    q = wb_dat_o;
    tk = cyc_n;
    wb_req <= '0;
    @(posedge clk);
  endtask : wb
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] x;
    wb(1'b1, a, d, x);
  endtask : wr
  task automatic rchk(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask : rchk
  // Writes control; the one-shot clear bit is not kept for later writes.
  task automatic setc(input logic [31:0] v);
    ctl_v = v & 32'hFFFFFFBF;
    wr(CTL, v);
  endtask : setc
  task automatic cap(output logic [31:0] q, output time t);
    wr(CTL, ctl_v | 32'h80);
    t = tk;
    wb(1'b0, CAP, 32'h0, q);
  endtask : cap
  task automatic mv(input bit up, input int k, input int r);
    repeat (r) sensor_model_inst.move(up, k, HOLD);
  endtask : mv
  task automatic t_regs();
    rchk(WRP, {8'h00, position_counter_pkg::WRAP_RESET}, '1);
    rchk(CMPR, {8'h00, position_counter_pkg::COMPARE_RESET}, '1);
    wr(CAP, 32'h00ABCDEF);
    rchk(CAP, 32'h0, '1);
    rchk(4'h2, 32'h0, '1);
    wr(CMPR, 32'h00123456);
    rchk(CMPR, 32'h00123456, '1);
    for (int m = 0; m < 4; m++) begin
      setc(32'(m));
      rchk(CTL, 32'(m), 32'h3);
    end
    $display("regs done");
  endtask : t_regs
  task automatic t_enc();
    wr(WRP, 32'h5);
    setc(32'h00010050);
    n = tog_n;
    mv(1'b1, 0, 7);
    cap(c1, t0);
    chk(c1, 32'h1);
    chk(32'(tog_n - n), 32'h3);
    rchk(CTL, 32'h100, 32'h100);
    mv(1'b0, 0, 3);
    cap(c1, t0);
    chk(c1, 32'h4);
    rchk(CTL, 32'h200, 32'h300);
    rchk(CTL, 32'h0, 32'h200);
    mv(1'b1, 0, 1);
    rchk(CTL, 32'h100, 32'h100);
    setc(32'h0);
    rchk(CTL, 32'h0, 32'h100);
    rchk(CAP, 32'h4, '1);
    $display("encoder done");
  endtask : t_enc
  task automatic t_index();
    wr(CMPR, 32'h2);
    setc(32'h74);
    n = irq_n;
    mv(1'b1, 0, 3);
    chk(32'(irq_n - n), 32'h0);
    sensor_model_inst.zset(1'b1);
    rchk(CTL, 32'h400, 32'h400);
    cap(c1, t0);
    chk(c1, 32'h0);
    mv(1'b1, 0, 2);
    sensor_model_inst.zset(1'b0);
    chk(32'(irq_n - n), 32'h1);
    cap(c1, t0);
    chk(c1, 32'h2);
    mv(1'b0, 0, 1);
    sensor_model_inst.zset(1'b1);
    cap(c1, t0);
    chk(c1, 32'h1);
    sensor_model_inst.zset(1'b0);
    cap(c1, t0);
    chk(c1, 32'h0);
    $display("index done");
  endtask : t_index
  task automatic t_event();
    for (int k = 0; k < 2; k++) begin
      setc(32'h11 | 32'(k << 3));
      mv(1'b1, k, 2);
      setc(32'h51 | 32'(k << 3));
      mv(1'b0, k, 1);
      cap(c1, t0);
      chk(c1, 32'hFFFF);
      mv(1'b1, k, 7);
      cap(c1, t0);
      chk(c1, 32'h6);
    end
    $display("event done");
  endtask : t_event
  task automatic t_timer();
    setc(32'h12);
    mv(1'b1, 0, 3);
    wb(1'b0, CAP, 32'h0, c1);
    sensor_model_inst.move(1'b1, 0, HOLD + 5);
    mv(1'b1, 0, 1);
    wb(1'b0, CAP, 32'h0, c2);
    chk(c2 - c1, 32'h5);
    setc(32'h53);
    t2 = tk;
    cap(c1, t0);
    chk(c1, 32'(t0 - t2 - 1));
    repeat (20) @(posedge clk);
    cap(c2, t2);
    chk(c2 - c1, 32'(t2 - t0));
    $display("timer done");
  endtask : t_timer
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  // Free-running clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Main sequence.
  initial begin
    nrst      = 1'b0;
    wb_req    = '0;
    dp_p      = 1'b0;
    err_total = 0;
    checks    = 0;
    irq_n     = 0;
    tog_n     = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs();
    t_enc();
    t_index();
    t_event();
    t_timer();
    finish_test();
  end
  // Cuts a hang short.
  initial begin
    #200000;
    $display("[FAIL] %0t run timed out", $time);
    err_total++;
    finish_test();
  end
endmodule : testbench
